// >>> rtl/adccal_ctrl.sv
/*
 * adccal_ctrl: apb slave holding the calibration control register, the
 * sequencer that issues converter readings during a calibration cycle,
 * and a sticky interrupt status with mask.
 * assumes an external converter core that takes one-cycle read requests
 * and answers each with a one-cycle done pulse; one clock, mclk.
 */
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - bit 7 is a read-only busy flag high for the whole of a conversion or calibration and cleared by hardware at its end.
// - bit 6 set to one inhibits gain calibration, zero permits it.
// - select code 00, 01, 10, 11 averages 15, 1, 31 or 63 readings per calibration.
// - bit 1 zero selects offset calibration and one selects gain calibration.
// - setting bit 0 starts the selected calibration with the selected averaging count.
// - bit 0 clears itself when the calibration completes.
// - the control register reads zero after reset.
module adccal_ctrl
  import adccal_pkg::*;
(
  input wire logic mclk,            // core clock
  input wire logic rst_n,           // async reset, active low
  input wire logic psel,            // apb select
  input wire logic penable,         // apb access phase
  input wire logic pwrite,          // apb direction
  input wire logic [7:0] paddr,     // apb byte address
  input wire logic [31:0] pwdata,   // apb write data
  output logic [31:0] prdata,       // apb read data
  output logic pready,              // apb ready
  output logic pslverr,             // apb error on unmapped address
  input wire logic conv_start,      // request of an ordinary conversion
  output logic conv_req,            // one-cycle reading request to core
  output logic conv_is_cal,         // request belongs to calibration
  output logic cal_type_gain,       // calibration kind for the core
  input wire logic conv_done,       // core finished one reading
  output logic cal_coef_load,       // pulse: calibration result valid
  output logic irq                  // level interrupt
);

  adccal_state_t state_r, state_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic req_r, req_nxt;
  logic load_r;
  logic [2:0] ist_r, ist_nxt, imask_r, imask_nxt;
  logic [31:0] prdata_r;

  function automatic logic [5:0] avg_count(input logic [1:0] sel);
    unique case (sel)
      2'b00: avg_count = ADCCAL_AVG_00;
      2'b01: avg_count = ADCCAL_AVG_01;
      2'b10: avg_count = ADCCAL_AVG_10;
      2'b11: avg_count = ADCCAL_AVG_11;
    endcase
  endfunction : avg_count

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = paddr == ADCCAL_OFS_CTRL;
  wire hit_ist = paddr == ADCCAL_OFS_INT_STAT;
  wire hit_imask = paddr == ADCCAL_OFS_INT_MASK;
  wire mapped = hit_ctrl || hit_ist || hit_imask;
  wire wr_ctrl = wr && hit_ctrl;
  wire busy = state_r != ADCCAL_IDLE;
  wire want_start = wr_ctrl && pwdata[ADCCAL_BIT_START] && !busy;
  wire want_gain = pwdata[ADCCAL_BIT_TYPE];
  // gain run asked for while inhibited: start bit is refused
  wire gain_blocked = want_start && want_gain
                      && pwdata[ADCCAL_BIT_GAIN_DIS];
  wire cal_go = want_start && !gain_blocked;
  wire conv_go = conv_start && !busy && !wr_ctrl;
  wire last_read = state_r == ADCCAL_CAL && conv_done
                   && cnt_r == 6'h01;
  wire cal_end = last_read;
  wire conv_end = state_r == ADCCAL_CONV && conv_done;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    req_nxt = 1'b0;
    unique case (state_r)
      ADCCAL_IDLE: begin
        if (cal_go) begin
          state_nxt = ADCCAL_CAL;
          // count chosen from the value being written
          cnt_nxt = avg_count(pwdata[ADCCAL_BIT_AVG_HI:ADCCAL_BIT_AVG_LO]);
          req_nxt = 1'b1;
        end else if (conv_go) begin
          state_nxt = ADCCAL_CONV;
          req_nxt = 1'b1;
        end
      end
      ADCCAL_CAL: begin
        if (conv_done) begin
          if (cal_end) begin
            state_nxt = ADCCAL_IDLE;
            cnt_nxt = ADCCAL_CNT_RST;
          end else begin
            cnt_nxt = cnt_r - 6'h01;
            req_nxt = 1'b1;
          end
        end
      end
      ADCCAL_CONV: begin
        if (conv_done) begin
          state_nxt = ADCCAL_IDLE;
        end
      end
      default: begin
        state_nxt = ADCCAL_IDLE;
      end
    endcase
  end

  // software bits 6..1 write only while idle; busy bit is never stored
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl && !busy) begin
      ctrl_nxt[ADCCAL_BIT_GAIN_DIS:ADCCAL_BIT_TYPE] =
        pwdata[ADCCAL_BIT_GAIN_DIS:ADCCAL_BIT_TYPE];
      ctrl_nxt[ADCCAL_BIT_START] = cal_go;
    end
    if (cal_end) begin
      ctrl_nxt[ADCCAL_BIT_START] = 1'b0;
    end
    ctrl_nxt[ADCCAL_BIT_BUSY] = 1'b0;
  end

  // set wins over write-one-to-clear
  wire [2:0] ist_set = {gain_blocked, conv_end, cal_end};
  always_comb begin
    ist_nxt = ist_r;
    if (wr && hit_ist) begin
      ist_nxt = ist_r & ~pwdata[2:0];
    end
    ist_nxt = ist_nxt | ist_set;
    imask_nxt = (wr && hit_imask) ? pwdata[2:0] : imask_r;
  end

  wire [7:0] ctrl_view = {busy, ctrl_r[6:0]};
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_view} :
                       hit_ist ? {29'h0000000, ist_r} :
                       hit_imask ? {29'h0000000, imask_r} : 32'h00000000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ADCCAL_IDLE;
      ctrl_r <= ADCCAL_CTRL_RST;
      cnt_r <= ADCCAL_CNT_RST;
      req_r <= 1'b0;
      load_r <= 1'b0;
      ist_r <= ADCCAL_IRQ_RST;
      imask_r <= ADCCAL_IRQ_RST;
      prdata_r <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      cnt_r <= cnt_nxt;
      req_r <= req_nxt;
      load_r <= cal_end;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      if (psel && !penable && !pwrite) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // read data is latched in setup, so every access takes two cycles
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_r;
  assign conv_req = req_r;
  assign conv_is_cal = state_r == ADCCAL_CAL;
  assign cal_type_gain = ctrl_r[ADCCAL_BIT_TYPE];
  assign cal_coef_load = load_r;
  assign irq = |(ist_r & imask_r);

endmodule : adccal_ctrl

`default_nettype wire

// >>> rtl/adccal_pkg.sv
/*
 * adccal_pkg: register offsets, field positions, reset values, state and
 * averaging constants for the converter calibration control block.
 * assumes nothing of its surroundings.
 */
package adccal_pkg;
  // byte addresses on the apb bus
  localparam logic [7:0] ADCCAL_OFS_CTRL = 8'h00;
  localparam logic [7:0] ADCCAL_OFS_INT_STAT = 8'h04;
  localparam logic [7:0] ADCCAL_OFS_INT_MASK = 8'h08;
  // control register field positions
  localparam int ADCCAL_BIT_BUSY = 7;
  localparam int ADCCAL_BIT_GAIN_DIS = 6;
  localparam int ADCCAL_BIT_AVG_HI = 5;
  localparam int ADCCAL_BIT_AVG_LO = 4;
  localparam int ADCCAL_BIT_RSVD3 = 3;
  localparam int ADCCAL_BIT_RSVD2 = 2;
  localparam int ADCCAL_BIT_TYPE = 1;
  localparam int ADCCAL_BIT_START = 0;
  localparam logic [7:0] ADCCAL_CTRL_RST = 8'h00;
  // interrupt status bits
  localparam int ADCCAL_IRQ_CAL_DONE = 0;
  localparam int ADCCAL_IRQ_CONV_DONE = 1;
  localparam int ADCCAL_IRQ_GAIN_BLOCKED = 2;
  localparam logic [2:0] ADCCAL_IRQ_RST = 3'h0;
  // averaging counts per select code
  localparam logic [5:0] ADCCAL_AVG_00 = 6'h0F;
  localparam logic [5:0] ADCCAL_AVG_01 = 6'h01;
  localparam logic [5:0] ADCCAL_AVG_10 = 6'h1F;
  localparam logic [5:0] ADCCAL_AVG_11 = 6'h3F;
  localparam logic [5:0] ADCCAL_CNT_RST = 6'h00;
  typedef enum logic [1:0] {
    ADCCAL_IDLE = 2'b00,
    ADCCAL_CAL = 2'b01,
    ADCCAL_CONV = 2'b11
  } adccal_state_t;
endpackage : adccal_pkg

// >>> dv/adccal_chk.sv
/* adccal_chk: port assertions for the calibration control block.
   assumes one clock, mclk, and async active-low rst_n. */
`timescale 1ns/1ns
`default_nettype none
module adccal_chk
  import adccal_pkg::*;
(
  input wire logic mclk, rst_n, psel, penable, pwrite, // bus
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, prdata, // data
  input wire logic pready, pslverr, conv_start, conv_req, // misc
  input wire logic conv_is_cal, cal_type_gain, conv_done, // core
  input wire logic cal_coef_load, irq // results
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [6:0] nreq_r;
  wire wr_c = psel && penable && pwrite && paddr == ADCCAL_OFS_CTRL;
  // counts readings of the running calibration only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) nreq_r <= 7'h00;
    else if (!conv_is_cal) nreq_r <= 7'h00;
    else if (conv_req) nreq_r <= nreq_r + 7'h01;
  end
  property p_rst; $rose(rst_n) |-> !conv_is_cal && !irq; endproperty
  a_rst: assert property (p_rst) else $error("not idle");
  property p_req; $rose(conv_is_cal) |-> conv_req; endproperty
  a_req: assert property (p_req) else $error("no reading");
  property p_typ; $rose(conv_is_cal) |-> cal_type_gain == $past(pwdata[1]);
  endproperty
  a_typ: assert property (p_typ) else $error("bad kind");
  property p_gd; wr_c && pwdata[1] && pwdata[6] |=> !$rose(conv_is_cal);
  endproperty
  a_gd: assert property (p_gd) else $error("gain ran");
  property p_bsy; conv_is_cal && !conv_done |=> conv_is_cal; endproperty
  a_bsy: assert property (p_bsy) else $error("early end");
  property p_ign; wr_c && !pwdata[0] && !conv_is_cal |=> !conv_is_cal;
  endproperty
  a_ign: assert property (p_ign) else $error("busy written");
  property p_coef; $fell(conv_is_cal) |-> ##[0:1] cal_coef_load; endproperty
  a_coef: assert property (p_coef) else $error("no result");
  property p_avg;
    $fell(conv_is_cal) |-> nreq_r inside {7'h01, 7'h0F, 7'h1F, 7'h3F};
  endproperty
  a_avg: assert property (p_avg) else $error("bad count");
  c_gain: cover property (conv_is_cal && cal_type_gain);
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
endmodule : adccal_chk
bind adccal_ctrl adccal_chk u_chk (.mclk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_start,
  .conv_req, .conv_is_cal, .cal_type_gain, .conv_done, .cal_coef_load, .irq);
`default_nettype wire

// >>> dv/adccal_ctrl_tb.sv
/* adccal_ctrl_tb: apb scenarios for the calibration control block.
   assumes the checker binds itself; the core answers next cycle. */
`timescale 1ns/1ns
`default_nettype none
module adccal_ctrl_tb;
  import adccal_pkg::*;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic conv_start = 0, conv_done = 0, pready, pslverr, conv_req, err;
  logic conv_is_cal, cal_type_gain, cal_coef_load, irq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int mismatches = 0, samples_checked = 0, nreq = 0;
  adccal_ctrl u_dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .conv_start, .conv_req,
    .conv_is_cal, .cal_type_gain, .conv_done, .cal_coef_load, .irq);
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) begin
    conv_done <= conv_req;
    if (conv_req) nreq <= nreq + 1;
  end
  task chk(input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task apb(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwdata <= d;
    pwrite <= w;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task t_reset;
    apb(ADCCAL_OFS_CTRL, 32'h0, 0);
    chk(rd, 32'h0);
    apb(ADCCAL_OFS_CTRL, 32'h80, 1);
    apb(ADCCAL_OFS_CTRL, 32'h0, 0);
    chk(rd, 32'h0);
    apb(8'h0C, 32'h0, 0);
    chk(err, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task t_cal;
    logic [31:0] avg [4] = '{32'h0F, 32'h01, 32'h1F, 32'h3F};
    logic [31:0] w;
    for (int c = 0; c < 4; c++) begin
      w = 32'h05 | (c << 4) | ((c & 1) << 1);
      nreq = 0;
      apb(ADCCAL_OFS_CTRL, w, 1);
      apb(ADCCAL_OFS_CTRL, 32'h0, 0);
      chk(rd, w | 32'h80);
      chk(cal_type_gain, c & 1);
      for (int n = 0; n < 200 && rd[0]; n++) apb(ADCCAL_OFS_CTRL, 32'h0, 0);
      chk(rd, w & 32'h7E);
      chk(nreq, avg[c]);
      apb(ADCCAL_OFS_INT_STAT, 32'h1, 1);
    end
    $display("calibration test done");
  endtask : t_cal
  task t_gdis;
    apb(ADCCAL_OFS_CTRL, 32'h47, 1);
    apb(ADCCAL_OFS_CTRL, 32'h0, 0);
    chk(rd, 32'h46);
    apb(ADCCAL_OFS_INT_STAT, 32'h0, 0);
    chk(rd, 32'h4);
    apb(ADCCAL_OFS_INT_MASK, 32'h4, 1);
    @(negedge mclk);
    chk(irq, 1'b1);
    apb(ADCCAL_OFS_INT_STAT, 32'h4, 1);
    @(negedge mclk);
    chk(irq, 1'b0);
    $display("gain disable test done");
  endtask : t_gdis
  task t_conv;
    @(posedge mclk);
    conv_start <= 1;
    @(posedge mclk);
    conv_start <= 0;
    apb(ADCCAL_OFS_CTRL, 32'h0, 0);
    chk(rd[7], 1'b1);
    apb(ADCCAL_OFS_CTRL, 32'h0, 0);
    chk(rd[7], 1'b0);
    apb(ADCCAL_OFS_INT_STAT, 32'h0, 0);
    chk(rd, 32'h2);
    apb(ADCCAL_OFS_INT_STAT, 32'h2, 1);
    $display("conversion test done");
  endtask : t_conv
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    t_reset;
    t_cal;
    t_gdis;
    t_conv;
    close_out;
  end
  // all scenarios take a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    close_out;
  end
endmodule : adccal_ctrl_tb
`default_nettype wire
